// ---- rtl/mdspi_cfg.svh ----
// constants of the motor driver serial slave link
// assumes ref_clk at 100 MHz and a mode 3 master at up to 1 MHz
`ifndef MDSPI_CFG_SVH
`define MDSPI_CFG_SVH
`define MDSPI_WORD_BITS      16
`define MDSPI_HDR_WORDS      6'd2
`define MDSPI_MAX_DATA_WORDS 6'd32
`define MDSPI_CMD_WRITE      8'h02
`define MDSPI_CMD_READ       8'h03
`define MDSPI_ADDR_STEP      8'h02
`define MDSPI_FRAME_GAP_MS   1
`define MDSPI_REF_CLK_MHZ    100
`define MDSPI_GAP_CYCLES     (`MDSPI_FRAME_GAP_MS * 1000 * `MDSPI_REF_CLK_MHZ)
`endif

// ---- rtl/mdspi_pkg.sv ----
// types shared by the serial slave link modules
// assumes mdspi_cfg.svh for the numeric constants
package mdspi_pkg;
    typedef logic [15:0] mdspi_word_t;
    typedef enum logic [1:0] {
        MDSPI_IDLE  = 2'b00,
        MDSPI_FRAME = 2'b01,
        MDSPI_GAP   = 2'b10,
        MDSPI_SKIP  = 2'b11
    } mdspi_state_t;
endpackage

// ---- rtl/mdspi_word_if.sv ----
// word carrier between the link shifter and the core side
// assumes rx_word stays still for a whole word time after each toggle
`timescale 1ns/1ns
`default_nettype none
interface mdspi_word_if;
    import mdspi_pkg::*;
    mdspi_word_t rx_word;
    logic        rx_toggle;
    mdspi_word_t tx_word;
    modport link (output rx_word, output rx_toggle, input tx_word);
    modport core (input rx_word, input rx_toggle, output tx_word);
endinterface
`default_nettype wire

// ---- rtl/mdspi_shifter.sv ----
// serial shifter running on the master's clock
// assumes sck idles high between frames and stands still outside them
`timescale 1ns/1ns
`default_nettype none
`include "mdspi_cfg.svh"
module mdspi_shifter
    import mdspi_pkg::*;
(
    input  wire logic   spi_sck,  // link clock from master
    input  wire logic   spi_ss_n, // select, active low
    input  wire logic   spi_mosi, // serial data in
    input  wire logic   reset_n,  // async reset, active low
    output var  logic   spi_miso, // serial data out
    mdspi_word_if.link  wbus      // words to and from the core
);
    logic [3:0]  bit_cnt;
    logic [14:0] rx_shift;
    logic [14:0] tx_shift;

    // select high holds the counters cleared, so a partial word is lost
    always_ff @(posedge spi_sck or posedge spi_ss_n) begin
        if (spi_ss_n) begin
            bit_cnt  <= 4'h0;
            rx_shift <= 15'h0000;
        end else begin
            bit_cnt  <= bit_cnt + 4'h1;
            rx_shift <= {rx_shift[13:0], spi_mosi};
        end
    end

    // toggle survives select so the core never sees a false edge
    always_ff @(posedge spi_sck or negedge reset_n) begin
        if (!reset_n) begin
            wbus.rx_word   <= 16'h0000;
            wbus.rx_toggle <= 1'b0;
        end else if (!spi_ss_n && bit_cnt == 4'hf) begin
            wbus.rx_word   <= {rx_shift, spi_mosi};
            wbus.rx_toggle <= ~wbus.rx_toggle;
        end
    end

    // first fall of a word loads the new word, msb out first
    always_ff @(negedge spi_sck or posedge spi_ss_n) begin
        if (spi_ss_n) begin
            spi_miso <= 1'b0;
            tx_shift <= 15'h0000;
        end else if (bit_cnt == 4'h0) begin
            spi_miso <= wbus.tx_word[15];
            tx_shift <= wbus.tx_word[14:0];
        end else begin
            spi_miso <= tx_shift[14];
            tx_shift <= {tx_shift[13:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

// ---- rtl/mdspi_link.sv ----
// top of the motor driver serial slave link: frame decode and gap timing
// assumes the settings store answers rd_data one ref_clk after rd_req
`timescale 1ns/1ns
`default_nettype none
`include "mdspi_cfg.svh"
module mdspi_link
    import mdspi_pkg::*;
#(
    parameter int GAP_CYCLES = `MDSPI_GAP_CYCLES // idle time after a frame
)(
    input  wire logic        ref_clk,       // core clock, 100 MHz
    input  wire logic        reset_n,       // async reset, active low
    input  wire logic        spi_sck,       // serial clock from master
    input  wire logic        spi_ss_n,      // slave select, active low
    input  wire logic        spi_mosi,      // serial data from master
    output var  logic        spi_miso,      // serial data to master
    output var  logic        spi_miso_oe_n, // miso drive enable, low drives
    input  wire mdspi_word_t status0,       // first status word
    input  wire mdspi_word_t status1,       // second status word
    input  wire mdspi_word_t rd_data,       // setting read back
    output var  logic        rd_req,        // read request pulse
    output var  logic [7:0]  rd_addr,       // read address, even
    output var  logic        wr_valid,      // write pulse
    output var  logic [7:0]  wr_addr,       // write address, even
    output var  mdspi_word_t wr_data,       // write data
    output var  logic        cmd_valid,     // header complete pulse
    output var  logic [7:0]  cmd_code,      // command byte of the frame
    output var  logic        frame_busy     // frame or gap in progress
);
    localparam int GAP_W = $clog2(GAP_CYCLES + 1);

    generate
        if (GAP_CYCLES < 1) begin : g_bad_gap
            $error("GAP_CYCLES must be at least one");
        end
    endgenerate

    function automatic logic [7:0] step_addr(input logic [7:0] a);
        step_addr = a + `MDSPI_ADDR_STEP;
    endfunction

    mdspi_word_if wbus ();

    mdspi_shifter mdspi_shifter_inst (
        .spi_sck  (spi_sck),
        .spi_ss_n (spi_ss_n),
        .spi_mosi (spi_mosi),
        .reset_n  (reset_n),
        .spi_miso (spi_miso),
        .wbus     (wbus)
    );

    logic         ss_meta;
    logic         ss_sync;
    logic         ss_prev;
    logic         tg_meta;
    logic         tg_sync;
    logic         tg_prev;
    mdspi_state_t state;
    mdspi_state_t next_state;
    logic [GAP_W-1:0] gap_cnt;
    logic [5:0]   word_idx;
    logic [7:0]   base_addr;
    logic [7:0]   next_addr;
    logic         rd_pend;
    logic         ss_fall;
    logic         ss_rise;
    logic         rx_new;
    logic         data_word;

    // level crossings of select and the word toggle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ss_meta <= 1'b1;
            ss_sync <= 1'b1;
            ss_prev <= 1'b1;
            tg_meta <= 1'b0;
            tg_sync <= 1'b0;
            tg_prev <= 1'b0;
        end else begin
            ss_meta <= spi_ss_n;
            ss_sync <= ss_meta;
            ss_prev <= ss_sync;
            tg_meta <= wbus.rx_toggle;
            tg_sync <= tg_meta;
            tg_prev <= tg_sync;
        end
    end

    assign ss_fall   = ss_prev && !ss_sync;
    assign ss_rise   = !ss_prev && ss_sync;
    assign rx_new    = tg_sync != tg_prev;
    assign data_word = word_idx >= `MDSPI_HDR_WORDS &&
                       word_idx < `MDSPI_HDR_WORDS + `MDSPI_MAX_DATA_WORDS;

    // released within a few core cycles, well inside the access time
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            spi_miso_oe_n <= 1'b1;
        end else begin
            spi_miso_oe_n <= ss_sync;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            MDSPI_IDLE: begin
                if (ss_fall) begin
                    next_state = MDSPI_FRAME;
                end
            end
            MDSPI_FRAME: begin
                if (ss_rise) begin
                    next_state = MDSPI_GAP;
                end
            end
            MDSPI_GAP: begin
                if (ss_fall) begin
                    next_state = MDSPI_SKIP;
                end else if (gap_cnt == '0) begin
                    next_state = MDSPI_IDLE;
                end
            end
            MDSPI_SKIP: begin
                if (ss_rise) begin
                    next_state = MDSPI_GAP;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= MDSPI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // gap restarts after an early frame, which was not served
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_cnt <= '0;
        end else if (ss_rise) begin
            gap_cnt <= GAP_W'(GAP_CYCLES - 1);
        end else if (state == MDSPI_GAP && gap_cnt != '0) begin
            gap_cnt <= gap_cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_busy <= 1'b0;
        end else begin
            frame_busy <= next_state != MDSPI_IDLE;
        end
    end

    // words counted only inside an accepted frame
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_idx <= 6'h00;
        end else if (ss_fall) begin
            word_idx <= 6'h00;
        end else if (state == MDSPI_FRAME && rx_new &&
                     word_idx != `MDSPI_HDR_WORDS + `MDSPI_MAX_DATA_WORDS) begin
            word_idx <= word_idx + 6'h01;
        end
    end

    // header decode, write and read sequencing
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_code  <= 8'h00;
            base_addr <= 8'h00;
            next_addr <= 8'h00;
            cmd_valid <= 1'b0;
            wr_valid  <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 16'h0000;
            rd_req    <= 1'b0;
            rd_addr   <= 8'h00;
        end else begin
            cmd_valid <= 1'b0;
            wr_valid  <= 1'b0;
            rd_req    <= 1'b0;
            if (state == MDSPI_FRAME && rx_new) begin
                if (word_idx == 6'h00) begin
                    cmd_code  <= wbus.rx_word[15:8];
                    base_addr <= {wbus.rx_word[7:1], 1'b0};
                end else if (word_idx == 6'h01) begin
                    // reserved halfword is not checked
                    cmd_valid <= 1'b1;
                    next_addr <= step_addr(base_addr);
                    if (cmd_code == `MDSPI_CMD_READ) begin
                        rd_req  <= 1'b1;
                        rd_addr <= base_addr;
                    end
                end else if (data_word) begin
                    next_addr <= step_addr(next_addr);
                    if (cmd_code == `MDSPI_CMD_WRITE) begin
                        wr_valid <= 1'b1;
                        wr_addr  <= word_idx == `MDSPI_HDR_WORDS ?
                                    base_addr : rd_addr;
                        wr_data  <= wbus.rx_word;
                    end else if (cmd_code == `MDSPI_CMD_READ) begin
                        rd_req  <= 1'b1;
                        rd_addr <= next_addr;
                    end
                    if (cmd_code == `MDSPI_CMD_WRITE) begin
                        rd_addr <= word_idx == `MDSPI_HDR_WORDS ?
                                   step_addr(base_addr) : step_addr(rd_addr);
                    end
                end
            end
        end
    end

    // tx word is quasi-static: changed well before the next word's first fall
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_pend      <= 1'b0;
            wbus.tx_word <= 16'h0000;
        end else begin
            rd_pend <= rd_req;
            if (state != MDSPI_FRAME) begin
                wbus.tx_word <= status0;
            end else if (rd_pend) begin
                wbus.tx_word <= rd_data;
            end else if (rx_new && word_idx == 6'h00) begin
                wbus.tx_word <= status1;
            end else if (rx_new && cmd_code != `MDSPI_CMD_READ) begin
                wbus.tx_word <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/mdspi_link_sva.sv ----
// checker of the serial slave link top ports
// bound to mdspi_link from the bench top; sees ports only
`timescale 1ns/1ns
`default_nettype none
module mdspi_link_sva #(
    parameter int GAP_CYCLES = 100000 // idle time after a frame
)(
    input wire logic       ref_clk,       // core clock
    input wire logic       reset_n,       // async reset, active low
    input wire logic       spi_ss_n,      // select, active low
    input wire logic       spi_miso_oe_n, // miso enable, low drives
    input wire logic       rd_req,        // read pulse
    input wire logic [7:0] rd_addr,       // read address
    input wire logic       wr_valid,      // write pulse
    input wire logic [7:0] wr_addr,       // write address
    input wire logic       cmd_valid,     // header pulse
    input wire logic       frame_busy     // frame or gap
);
    logic [31:0] idle_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // saturates so a long idle never wraps back into the gap
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) idle_cnt <= 32'h0;
        else if (!spi_ss_n) idle_cnt <= 32'h0;
        else if (idle_cnt != 32'hffffffff) idle_cnt <= idle_cnt + 32'h1;
    end
    a_oe_drive_sel: assert property ((!spi_ss_n)[*4] |-> !spi_miso_oe_n)
        else $error("miso not driven while selected");
    a_oe_release_idle: assert property (spi_ss_n[*4] |-> spi_miso_oe_n)
        else $error("miso driven while deselected");
    a_rd_one_cycle: assert property (rd_req |=> !rd_req)
        else $error("read request longer than one cycle");
    a_wr_one_cycle: assert property (wr_valid |=> !wr_valid)
        else $error("write pulse longer than one cycle");
    a_cmd_one_cycle: assert property (cmd_valid |=> !cmd_valid)
        else $error("header pulse longer than one cycle");
    a_rd_addr_even: assert property (rd_req |-> !rd_addr[0])
        else $error("odd read address");
    a_wr_addr_even: assert property (wr_valid |-> !wr_addr[0])
        else $error("odd write address");
    a_act_in_frame: assert property (
        (rd_req || wr_valid || cmd_valid) |-> frame_busy)
        else $error("activity outside a frame");
    a_busy_on_sel: assert property ($rose(frame_busy) |-> !spi_ss_n)
        else $error("busy rose without select");
    a_gap_min_len: assert property (
        $fell(frame_busy) |-> idle_cnt >= GAP_CYCLES)
        else $error("gap too short");
    a_gap_max_len: assert property (
        idle_cnt == GAP_CYCLES + 16 |-> !frame_busy)
        else $error("gap never ended");
    c_read: cover property (rd_req);
    c_write: cover property (wr_valid);
    c_gap_end: cover property ($fell(frame_busy));
endmodule
`default_nettype wire

// ---- dv/mdspi_master_model.sv ----
// serial master model: mode 3 frames, sck moves only inside frames except in the noise task
// assumes miso arrives already resolved with its pull-up
`timescale 1ns/1ns
`default_nettype none
module mdspi_master_model (
    output var  logic spi_sck,  // link clock, idles high
    output var  logic spi_ss_n, // select, active low
    output var  logic spi_mosi, // data to slave
    input  wire logic miso      // resolved miso wire
);
    logic [15:0] tx_q [40];
    logic [15:0] rx_q [40];
    initial begin
        spi_sck  = 1'b1;
        spi_ss_n = 1'b1;
        spi_mosi = 1'b1;
    end
    // n whole words, then cut bits of one partial word
    task automatic frame(input int n, input int cut);
        spi_ss_n = 1'b0;
        #103;
        for (int w = 0; w <= n; w++) begin
            for (int b = 15; b >= 0; b--) begin
                if (w == n && 15 - b >= cut) break;
                spi_sck  = 1'b0;
                spi_mosi = tx_q[w][b];
                #16;
                spi_sck = 1'b1;
                rx_q[w][b] = miso;
                #16;
            end
            // sck held high so the core can stage the next word
            #600;
        end
        spi_ss_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask
    task automatic noise();
        repeat (8) begin
            spi_sck  = ~spi_sck;
            spi_mosi = ~spi_mosi;
            #16;
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// bench top: random and corner frames through the slave link top
// assumes master model and checker compile first
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    n_mismatch++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tb;
    import mdspi_pkg::*;
    localparam int GAP = 200;
    logic        ref_clk, reset_n, spi_sck, spi_ss_n, spi_mosi, spi_miso;
    logic        spi_miso_oe_n, miso_wire, rd_req, wr_valid, cmd_valid;
    logic        frame_busy;
    logic [7:0]  rd_addr, wr_addr, cmd_code, cmd_seen;
    logic [7:0]  wr_a [40];
    mdspi_word_t status0, status1, rd_data, wr_data;
    mdspi_word_t wr_d [40];
    logic [31:0] rnd;
    int          wr_n, cmd_n, n_mismatch, checks_done;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic mdspi_word_t store(input logic [7:0] a);
        return {a, ~a} ^ 16'h5a3c;
    endfunction
    assign rd_data   = store(rd_addr);
    assign miso_wire = spi_miso_oe_n ? 1'b1 : spi_miso;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    mdspi_link #(.GAP_CYCLES(GAP)) mdspi_link_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .spi_sck(spi_sck),
        .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .status0(status0),
        .status1(status1), .rd_data(rd_data), .rd_req(rd_req),
        .rd_addr(rd_addr), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .frame_busy(frame_busy));
    mdspi_master_model mdspi_master_model_inst (
        .spi_sck(spi_sck), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
        .miso(miso_wire));
    always @(posedge ref_clk) begin
        if (wr_valid === 1'b1) begin
            wr_a[wr_n] = wr_addr;
            wr_d[wr_n] = wr_data;
            wr_n++;
        end
        if (cmd_valid === 1'b1) begin
            cmd_n++;
            cmd_seen = cmd_code;
        end
    end
    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic run_frame(input logic [7:0] cmd, input logic [7:0] adr,
                             input int n, input bit early, input int cut);
        logic [7:0] a;
        logic [7:0] ak;
        int         nd;
        a  = {adr[7:1], 1'b0};
        nd = (n > 32) ? 32 : n;
        // waiting out the gap keeps the master legal
        for (int i = 0; i < 4000 && !early && frame_busy !== 1'b0; i++)
            @(posedge ref_clk);
        @(posedge ref_clk);
        rnd = lfsr(rnd);
        status0 <= rnd[15:0];
        status1 <= rnd[31:16];
        mdspi_master_model_inst.tx_q[0] = {cmd, adr};
        mdspi_master_model_inst.tx_q[1] = 16'h0000;
        for (int k = 0; k <= n; k++) begin
            rnd = lfsr(rnd);
            mdspi_master_model_inst.tx_q[2 + k] =
                (cmd == 8'h03) ? 16'h0000 : rnd[15:0];
        end
        wr_n  = 0;
        cmd_n = 0;
        // select falls between core edges, never on a sampling edge
        @(negedge ref_clk);
        mdspi_master_model_inst.frame(n + 2, cut);
        repeat (20) @(posedge ref_clk);
        `CHK(mdspi_master_model_inst.rx_q[0], status0)
        `CHK(cmd_n, early ? 0 : 1)
        if (early)
            `CHK(wr_n, 0)
        else begin
            `CHK(cmd_seen, cmd)
            `CHK(mdspi_master_model_inst.rx_q[1], status1)
            `CHK(wr_n, (cmd == 8'h02) ? nd : 0)
            for (int k = 0; k < nd; k++) begin
                ak = a + 8'(2 * k);
                if (cmd == 8'h02) begin
                    `CHK(wr_a[k], ak)
                    `CHK(wr_d[k], mdspi_master_model_inst.tx_q[2 + k])
                end
                if (cmd == 8'h03)
                    `CHK(mdspi_master_model_inst.rx_q[2 + k], store(ak))
            end
        end
    endtask
    // about twice the longest legal run of all frames and gaps
    initial begin
        #600000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        reset_n     = 1'b0;
        status0     = 16'h0000;
        status1     = 16'h0000;
        rnd         = 32'h000117ff;
        wr_n        = 0;
        cmd_n       = 0;
        n_mismatch  = 0;
        checks_done = 0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        run_frame(8'h02, 8'h03, 3, 0, 0);  // odd start address
        run_frame(8'h03, 8'hc1, 32, 0, 0); // longest field, runs up to the top address
        run_frame(8'h03, 8'h10, 0, 0, 0);  // empty data field
        run_frame(8'h02, 8'h40, 35, 0, 0); // words past the limit dropped
        run_frame(8'h02, 8'h20, 2, 1, 0);  // starts inside the gap
        run_frame(8'h02, 8'h08, 2, 0, 7);  // select lifted mid-word
        mdspi_master_model_inst.noise();
        run_frame(8'h00, 8'h00, 1, 0, 0);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            run_frame(rnd[0] ? 8'h02 : 8'h03, rnd[15:8],
                      int'(rnd[21:16]) % 33, 0, 0);
        end
        finish_test();
    end
endmodule
bind mdspi_link mdspi_link_sva #(.GAP_CYCLES(GAP_CYCLES)) mdspi_link_sva_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .spi_ss_n(spi_ss_n),
    .spi_miso_oe_n(spi_miso_oe_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .cmd_valid(cmd_valid),
    .frame_busy(frame_busy));
`default_nettype wire
